// File: src/eap_status.sv
`timescale 1ns/1ps
module eap_status (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // line-side events
    input wire eap_pkg::eap_line_ev_t line_ev_in,
    // transmit data toward shifter
    output logic [7:0] tx_data_out,
    output logic tx_pending_out,
    // interrupt requests
    output eap_pkg::eap_irq_t irq_out
);
    logic [7:0] st1_r, st1_nxt;
    logic [1:0] st2_r, st2_nxt;
    logic [7:0] rxbuf_r, rxbuf_nxt;
    logic [7:0] txbuf_r, txbuf_nxt;
    logic ninth_r, ninth_nxt;
    logic [eap_pkg::CTL_WIDTH-1:0] ctl_r, ctl_nxt;
    logic [7:0] latch1_r, latch1_nxt;
    logic [1:0] latch2_r, latch2_nxt;
    logic idle_armed_r, idle_armed_nxt;
    logic brk_armed_r, brk_armed_nxt;
    logic txp_r, txp_nxt;
    logic rx_en_d_r;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    eap_pkg::eap_irq_t irq_r, irq_nxt;

    logic acc, rd, wr;
    assign acc = psel_in && penable_in && !pready_r;
    assign rd = acc && !pwrite_in;
    assign wr = acc && pwrite_in;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        return a == b;
    endfunction

    logic rd_s1, rd_s2, rd_db, wr_db, wr_ctl;
    assign rd_s1 = rd && hit(paddr_in, eap_pkg::ADDR_STATUS_ONE);
    assign rd_s2 = rd && hit(paddr_in, eap_pkg::ADDR_STATUS_TWO);
    assign rd_db = rd && hit(paddr_in, eap_pkg::ADDR_DATA_BUF);
    // byte lane 0 carries all data buffer bits
    assign wr_db = wr && hit(paddr_in, eap_pkg::ADDR_DATA_BUF) && pstrb_in[0];
    assign wr_ctl = wr && hit(paddr_in, eap_pkg::ADDR_CONTROL);

    always_comb begin
        logic [7:0] s1;
        logic [1:0] s2;
        logic overrun_ev;
        s1 = st1_r;
        s2 = st2_r;
        latch1_nxt = latch1_r;
        latch2_nxt = latch2_r;
        idle_armed_nxt = idle_armed_r;
        brk_armed_nxt = brk_armed_r;
        rxbuf_nxt = rxbuf_r;
        ninth_nxt = ninth_r;
        txbuf_nxt = txbuf_r;
        txp_nxt = txp_r;
        ctl_nxt = ctl_r;
        overrun_ev = line_ev_in.rx_done && st1_r[eap_pkg::BIT_RX_FULL];
        // clears first so that same-cycle events win
        if (rd_s1) begin
            latch1_nxt = st1_r;
        end
        if (rd_s2) begin
            latch2_nxt = st2_r;
        end
        if (rd_db) begin
            s1[5:0] = st1_r[5:0] & ~latch1_r[5:0];
            s2[eap_pkg::BIT_BREAK] = st2_r[eap_pkg::BIT_BREAK] &
                                      ~latch2_r[eap_pkg::BIT_BREAK];
            if (latch1_r[eap_pkg::BIT_IDLE]) begin
                idle_armed_nxt = 1'b0;
            end
            latch1_nxt[5:0] = 6'h00;
            latch2_nxt[eap_pkg::BIT_BREAK] = 1'b0;
        end
        if (wr_db) begin
            txbuf_nxt = pwdata_in[7:0];
            txp_nxt = 1'b1;
            if (latch1_r[eap_pkg::BIT_TX_EMPTY]) begin
                s1[eap_pkg::BIT_TX_EMPTY] = 1'b0;
            end
            latch1_nxt[eap_pkg::BIT_TX_EMPTY] = 1'b0;
        end
        if (wr_ctl) begin
            ctl_nxt = pwdata_in[eap_pkg::CTL_WIDTH-1:0];
        end
        if (ctl_r[eap_pkg::CTL_RX_ENABLE] && !rx_en_d_r) begin
            idle_armed_nxt = 1'b0;
        end
        // transmit side
        if (line_ev_in.tx_load) begin
            s1[eap_pkg::BIT_TX_EMPTY] = 1'b1;
            txp_nxt = 1'b0;
        end
        if (line_ev_in.tx_queued || line_ev_in.tx_busy) begin
            s1[eap_pkg::BIT_TX_DONE] = 1'b0;
        end else if (s1[eap_pkg::BIT_TX_EMPTY] && !txp_nxt) begin
            s1[eap_pkg::BIT_TX_DONE] = 1'b1;
        end
        // receive side
        if (overrun_ev) begin
            s1[eap_pkg::BIT_OVERRUN] = 1'b1;
        end else if (line_ev_in.rx_done) begin
            rxbuf_nxt = line_ev_in.rx_char[7:0];
            ninth_nxt = ctl_r[eap_pkg::CTL_NINE_BIT] ? line_ev_in.rx_char[8]
                                                     : line_ev_in.rx_char[7];
            if (line_ev_in.brk && ctl_r[eap_pkg::CTL_NINE_BIT]) begin
                ninth_nxt = 1'b0;
            end
            s1[eap_pkg::BIT_RX_FULL] = 1'b1;
            idle_armed_nxt = 1'b1;
            if (line_ev_in.noise) s1[eap_pkg::BIT_NOISE] = 1'b1;
            if (line_ev_in.framing || line_ev_in.brk) begin
                s1[eap_pkg::BIT_FRAMING] = 1'b1;
            end
            if (line_ev_in.parity) s1[eap_pkg::BIT_PARITY] = 1'b1;
            if (line_ev_in.brk && brk_armed_r) begin
                s2[eap_pkg::BIT_BREAK] = 1'b1;
                brk_armed_nxt = 1'b0;
            end
        end
        if (line_ev_in.line_ones && !s2[eap_pkg::BIT_BREAK]) begin
            brk_armed_nxt = 1'b1;
        end
        if (line_ev_in.idle_seen && idle_armed_r) begin
            s1[eap_pkg::BIT_IDLE] = 1'b1;
        end
        if (line_ev_in.start_zero) begin
            s2[eap_pkg::BIT_RX_ACTIVE] = 1'b1;
        end else if (line_ev_in.false_start || line_ev_in.idle_seen || line_ev_in.rx_done) begin
            s2[eap_pkg::BIT_RX_ACTIVE] = 1'b0;
        end
        st1_nxt = s1;
        st2_nxt = s2;
        irq_nxt.tx_irq = (s1[eap_pkg::BIT_TX_EMPTY] && ctl_r[eap_pkg::CTL_TX_EMPTY_IE]) ||
                         (s1[eap_pkg::BIT_TX_DONE] && ctl_r[eap_pkg::CTL_TX_DONE_IE]);
        irq_nxt.rx_irq = (s1[eap_pkg::BIT_RX_FULL] && ctl_r[eap_pkg::CTL_RX_FULL_IE]) ||
                         (s1[eap_pkg::BIT_IDLE] && ctl_r[eap_pkg::CTL_IDLE_IE]);
        irq_nxt.err_irq = (s1[eap_pkg::BIT_OVERRUN] && ctl_r[eap_pkg::CTL_OVERRUN_IE]) ||
                          (s1[eap_pkg::BIT_NOISE] && ctl_r[eap_pkg::CTL_NOISE_IE]) ||
                          (s1[eap_pkg::BIT_FRAMING] && ctl_r[eap_pkg::CTL_FRAMING_IE]) ||
                          (s1[eap_pkg::BIT_PARITY] && ctl_r[eap_pkg::CTL_PARITY_IE]);
    end

    // bus answer: one wait state, unmapped addresses error
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        pready_nxt = acc;
        pslverr_nxt = 1'b0;
        if (rd_s1) prdata_nxt = {24'h00_0000, st1_r};
        else if (rd_s2) prdata_nxt = {30'h0000_0000, st2_r};
        else if (rd_db) prdata_nxt = {24'h00_0000, rxbuf_r};
        else if (rd && hit(paddr_in, eap_pkg::ADDR_CONTROL)) begin
            prdata_nxt = {22'h00_0000, ctl_r};
            prdata_nxt[eap_pkg::CTL_WIDTH] = ninth_r;
        end else if (acc && !wr_ctl && !hit(paddr_in, eap_pkg::ADDR_DATA_BUF)) begin
            pslverr_nxt = 1'b1;
        end
    end

    // data buffers deliberately untouched by reset
    always_ff @(posedge ref_clk_in) begin
        rxbuf_r <= rxbuf_nxt;
        txbuf_r <= txbuf_nxt;
        ninth_r <= ninth_nxt;
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st1_r <= eap_pkg::STATUS_ONE_RESET;
            st2_r <= 2'h0;
            ctl_r <= eap_pkg::CONTROL_RESET;
            latch1_r <= 8'h00;
            latch2_r <= 2'h0;
            idle_armed_r <= 1'b0;
            brk_armed_r <= 1'b1;
            txp_r <= 1'b0;
            rx_en_d_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= '0;
        end else begin
            st1_r <= st1_nxt;
            st2_r <= st2_nxt;
            ctl_r <= ctl_nxt;
            latch1_r <= latch1_nxt;
            latch2_r <= latch2_nxt;
            idle_armed_r <= idle_armed_nxt;
            brk_armed_r <= brk_armed_nxt;
            txp_r <= txp_nxt;
            rx_en_d_r <= ctl_r[eap_pkg::CTL_RX_ENABLE];
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign tx_data_out = txbuf_r;
    assign tx_pending_out = txp_r;
    assign irq_out = irq_r;

    // checks sit after the registers they watch
    // irq checks span two cycles since irq_r lags the enables in ctl_r by one

    a_overrun_keeps_buf: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (line_ev_in.rx_done && st1_r[eap_pkg::BIT_RX_FULL]) |=>
        (st1_r[eap_pkg::BIT_OVERRUN] && $stable(rxbuf_r)))
        else $error("overrun not flagged or buffer changed");

    a_rx_full_sets: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (line_ev_in.rx_done && !st1_r[eap_pkg::BIT_RX_FULL]) |=>
        st1_r[eap_pkg::BIT_RX_FULL] && rxbuf_r == $past(line_ev_in.rx_char[7:0]))
        else $error("rx full not set on receive");

    a_tx_empty_sets: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        line_ev_in.tx_load |=> st1_r[eap_pkg::BIT_TX_EMPTY])
        else $error("tx empty not set on load");

    a_tx_empty_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (wr_db && !latch1_r[eap_pkg::BIT_TX_EMPTY] && st1_r[eap_pkg::BIT_TX_EMPTY]) |=>
        st1_r[eap_pkg::BIT_TX_EMPTY])
        else $error("tx empty cleared without status read");

    a_tx_done_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        line_ev_in.tx_queued |=> !st1_r[eap_pkg::BIT_TX_DONE])
        else $error("tx done not cleared on queue");

    a_overrun_latched: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (rd_db && !latch1_r[eap_pkg::BIT_OVERRUN] && st1_r[eap_pkg::BIT_OVERRUN]) |=>
        st1_r[eap_pkg::BIT_OVERRUN])
        else $error("overrun cleared without prior status read");

    a_err_irq_gate: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_OVERRUN] && ctl_r[eap_pkg::CTL_OVERRUN_IE])[*2] |-> irq_r.err_irq)
        else $error("overrun irq missing");

    a_idle_needs_arm: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        $rose(st1_r[eap_pkg::BIT_IDLE]) |-> $past(idle_armed_r))
        else $error("idle set while unarmed");

    a_break_sets_fe: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        $rose(st2_r[eap_pkg::BIT_BREAK]) |-> st1_r[eap_pkg::BIT_FRAMING])
        else $error("break without framing flag");

    a_rx_active_set: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        line_ev_in.start_zero |=> st2_r[eap_pkg::BIT_RX_ACTIVE])
        else $error("rx active not set");

    a_tx_irq_gate: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_TX_EMPTY] && ctl_r[eap_pkg::CTL_TX_EMPTY_IE])[*2] |-> irq_r.tx_irq)
        else $error("tx empty irq missing");

    a_tx_done_irq: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_TX_DONE] && ctl_r[eap_pkg::CTL_TX_DONE_IE])[*2] |-> irq_r.tx_irq)
        else $error("tx done irq missing");

    a_rx_full_irq: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_RX_FULL] && ctl_r[eap_pkg::CTL_RX_FULL_IE])[*2] |-> irq_r.rx_irq)
        else $error("rx full irq missing");

    a_idle_irq_gate: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_IDLE] && ctl_r[eap_pkg::CTL_IDLE_IE])[*2] |-> irq_r.rx_irq)
        else $error("idle irq missing");

    a_noise_irq_gate: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_NOISE] && ctl_r[eap_pkg::CTL_NOISE_IE])[*2] |-> irq_r.err_irq)
        else $error("noise irq missing");

    a_framing_irq_gate: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_FRAMING] && ctl_r[eap_pkg::CTL_FRAMING_IE])[*2] |-> irq_r.err_irq)
        else $error("framing irq missing");

    a_parity_irq_gate: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_PARITY] && ctl_r[eap_pkg::CTL_PARITY_IE])[*2] |-> irq_r.err_irq)
        else $error("parity irq missing");

    a_tx_empty_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_TX_EMPTY] && !wr_db) |=> st1_r[eap_pkg::BIT_TX_EMPTY])
        else $error("tx empty cleared without data write");

    a_tx_done_sets: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_TX_EMPTY] && !txp_r && !wr_db && !line_ev_in.tx_queued &&
        !line_ev_in.tx_busy) |=> st1_r[eap_pkg::BIT_TX_DONE])
        else $error("tx done not set while idle");

    a_rx_full_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (st1_r[eap_pkg::BIT_RX_FULL] && !rd_db) |=> st1_r[eap_pkg::BIT_RX_FULL])
        else $error("rx full cleared without data read");

    a_rx_full_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (rd_db && latch1_r[eap_pkg::BIT_RX_FULL] && !line_ev_in.rx_done) |=>
        !st1_r[eap_pkg::BIT_RX_FULL])
        else $error("rx full not cleared by read pair");

    a_idle_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (rd_db && latch1_r[eap_pkg::BIT_IDLE] && !line_ev_in.idle_seen) |=>
        !st1_r[eap_pkg::BIT_IDLE])
        else $error("idle not cleared by read pair");

    a_overrun_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (rd_db && latch1_r[eap_pkg::BIT_OVERRUN] && !line_ev_in.rx_done) |=>
        !st1_r[eap_pkg::BIT_OVERRUN])
        else $error("overrun not cleared by read pair");

    a_noise_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (rd_db && latch1_r[eap_pkg::BIT_NOISE] && !line_ev_in.rx_done) |=>
        !st1_r[eap_pkg::BIT_NOISE])
        else $error("noise not cleared by read pair");

    a_framing_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (rd_db && latch1_r[eap_pkg::BIT_FRAMING] && !line_ev_in.rx_done) |=>
        !st1_r[eap_pkg::BIT_FRAMING])
        else $error("framing not cleared by read pair");

    a_parity_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (rd_db && latch1_r[eap_pkg::BIT_PARITY] && !line_ev_in.rx_done) |=>
        !st1_r[eap_pkg::BIT_PARITY])
        else $error("parity not cleared by read pair");

    a_break_rx_full: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        $rose(st2_r[eap_pkg::BIT_BREAK]) |-> st1_r[eap_pkg::BIT_RX_FULL])
        else $error("break without rx full");

    a_break_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (rd_db && latch2_r[eap_pkg::BIT_BREAK] && !line_ev_in.rx_done) |=>
        !st2_r[eap_pkg::BIT_BREAK])
        else $error("break not cleared by read pair");

    a_break_rearm: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        $rose(st2_r[eap_pkg::BIT_BREAK]) |-> $past(brk_armed_r))
        else $error("break set without rearm");

    a_rx_active_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (line_ev_in.false_start && !line_ev_in.start_zero) |=> !st2_r[eap_pkg::BIT_RX_ACTIVE])
        else $error("rx active not cleared on false start");

    a_ninth_copy: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (line_ev_in.rx_done && !st1_r[eap_pkg::BIT_RX_FULL] && !ctl_r[eap_pkg::CTL_NINE_BIT]) |=>
        ninth_r == $past(line_ev_in.rx_char[7]))
        else $error("ninth bit not copied from bit seven");

    a_latch_status: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rd_s1 |=> latch1_r == $past(st1_r))
        else $error("status one not latched on read");

    a_tx_load_done: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (line_ev_in.tx_load && !wr_db) |=> !tx_pending_out)
        else $error("tx pending kept after load");

    a_tx_buf_write: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        wr_db |=> tx_data_out == $past(pwdata_in[7:0]))
        else $error("data write not captured");

    a_pready_pulse: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        pready_r |=> !pready_r)
        else $error("pready longer than one cycle");
endmodule

// File: common/eap_pkg.sv
package eap_pkg;
    localparam logic [11:0] ADDR_STATUS_ONE = 12'h000;
    localparam logic [11:0] ADDR_STATUS_TWO = 12'h004;
    localparam logic [11:0] ADDR_DATA_BUF = 12'h008;
    localparam logic [11:0] ADDR_CONTROL = 12'h00c;
    // status one bit positions
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_TX_DONE = 6;
    localparam int BIT_RX_FULL = 5;
    localparam int BIT_IDLE = 4;
    localparam int BIT_OVERRUN = 3;
    localparam int BIT_NOISE = 2;
    localparam int BIT_FRAMING = 1;
    localparam int BIT_PARITY = 0;
    // status two bit positions
    localparam int BIT_BREAK = 1;
    localparam int BIT_RX_ACTIVE = 0;
    // control register bit positions (irq enables then modes)
    localparam int CTL_TX_EMPTY_IE = 0;
    localparam int CTL_TX_DONE_IE = 1;
    localparam int CTL_RX_FULL_IE = 2;
    localparam int CTL_IDLE_IE = 3;
    localparam int CTL_OVERRUN_IE = 4;
    localparam int CTL_NOISE_IE = 5;
    localparam int CTL_FRAMING_IE = 6;
    localparam int CTL_PARITY_IE = 7;
    localparam int CTL_NINE_BIT = 8;
    localparam int CTL_RX_ENABLE = 9;
    localparam int CTL_WIDTH = 10;
    localparam logic [7:0] STATUS_ONE_RESET = 8'hc0;
    localparam logic [CTL_WIDTH-1:0] CONTROL_RESET = 10'h000;

    // events from the line-side shift logic
    typedef struct packed {
        logic tx_load;
        logic tx_queued;
        logic tx_busy;
        logic rx_done;
        logic [8:0] rx_char;
        logic idle_seen;
        logic noise;
        logic framing;
        logic parity;
        logic brk;
        logic line_ones;
        logic start_zero;
        logic false_start;
    } eap_line_ev_t;

    typedef struct packed {
        logic tx_irq;
        logic rx_irq;
        logic err_irq;
    } eap_irq_t;
endpackage

// File: test/eap_line_model.sv
`timescale 1ns/1ps
module eap_line_model #(
    parameter int LOAD_WAIT = 12,
    parameter int BUSY_LEN = 30
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // transmit side of the block
    input wire logic tx_pending_in,
    input wire logic [7:0] tx_data_in,
    // events toward the block
    output eap_pkg::eap_line_ev_t line_ev_out
);
    logic [7:0] last_tx;
    int wait_c;
    int busy_c;

    initial line_ev_out = '0;

    always @(posedge ref_clk_in or posedge reset_in) begin
        line_ev_out.tx_load <= 1'b0;
        line_ev_out.tx_queued <= 1'b0;
        line_ev_out.tx_busy <= busy_c > 1;
        if (reset_in) begin
            wait_c <= 0;
            busy_c <= 0;
        end else if (busy_c > 0) begin
            busy_c <= busy_c - 1;
        end else if (tx_pending_in === 1'b1 && wait_c < LOAD_WAIT) begin
            wait_c <= wait_c + 1;
        end else if (tx_pending_in === 1'b1) begin
            // slow shifter: byte waits LOAD_WAIT cycles before it is taken
            wait_c <= 0;
            busy_c <= BUSY_LEN;
            last_tx <= tx_data_in;
            line_ev_out.tx_load <= 1'b1;
            line_ev_out.tx_queued <= 1'b1;
            line_ev_out.tx_busy <= 1'b1;
        end
    end

    // error bits in order noise, framing, parity, break
    task automatic rx(input logic [8:0] c, input logic [3:0] e);
        @(posedge ref_clk_in);
        line_ev_out.rx_done <= 1'b1;
        line_ev_out.rx_char <= c;
        {line_ev_out.noise, line_ev_out.framing, line_ev_out.parity, line_ev_out.brk} <= e;
        @(posedge ref_clk_in);
        line_ev_out.rx_done <= 1'b0;
        // stale char is not left on the bus
        line_ev_out.rx_char <= ~c;
        {line_ev_out.noise, line_ev_out.framing, line_ev_out.parity, line_ev_out.brk} <= 4'h0;
    endtask

    // idle, ones, start zero, false start
    task automatic ev(input logic [3:0] v);
        @(posedge ref_clk_in);
        {line_ev_out.idle_seen, line_ev_out.line_ones} <= v[3:2];
        {line_ev_out.start_zero, line_ev_out.false_start} <= v[1:0];
        @(posedge ref_clk_in);
        {line_ev_out.idle_seen, line_ev_out.line_ones} <= 2'b00;
        {line_ev_out.start_zero, line_ev_out.false_start} <= 2'b00;
    endtask
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam logic [11:0] S1 = eap_pkg::ADDR_STATUS_ONE;
    localparam logic [11:0] S2 = eap_pkg::ADDR_STATUS_TWO;
    localparam logic [11:0] DB = eap_pkg::ADDR_DATA_BUF;
    localparam logic [11:0] CT = eap_pkg::ADDR_CONTROL;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'hf;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    eap_pkg::eap_line_ev_t line_ev;
    logic [7:0] tx_data_out;
    logic tx_pending_out;
    eap_pkg::eap_irq_t irq_out;
    int err_count = 0;
    int samples_checked = 0;
    logic [31:0] q;
    logic e;

    always #5 ref_clk_in = ~ref_clk_in;

    eap_status u_eap_status (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .line_ev_in(line_ev),
        .tx_data_out(tx_data_out), .tx_pending_out(tx_pending_out), .irq_out(irq_out));
    eap_line_model u_eap_line_model (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .tx_pending_in(tx_pending_out), .tx_data_in(tx_data_out), .line_ev_out(line_ev));

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do @(posedge ref_clk_in); while (pready_out !== 1'b1 && ++n < 50);
        if (n >= 50) begin
            err_count++;
            $display("ERROR pready expected 1 seen %b", pready_out);
        end
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        samples_checked++;
        if (s !== x) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), x, q);
    endtask

    // clears latched rx flags, and break if status two was read before
    task automatic clr();
        apb(1'b0, S1, 32'h0);
        apb(1'b0, DB, 32'h0);
    endtask

    task automatic tx_wait();
        int i;
        for (i = 0; i < 100 && tx_pending_out !== 1'b0; i++) @(posedge ref_clk_in);
        if (tx_pending_out !== 1'b0) begin
            err_count++;
            $display("ERROR tx_pending expected 0 seen %b", tx_pending_out);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        rd(S2, 32'h0);
        apb(1'b1, DB, 32'h96);
        apb(1'b0, S1, 32'h0);
        chk("tx_empty", 1'b1, q[7]);
        tx_wait();
        repeat (40) @(posedge ref_clk_in);
        chk("tx byte", 8'h96, u_eap_line_model.last_tx);
        rd(S1, 32'hc0);
        apb(1'b1, DB, 32'ha5);
        chk("wr slverr", 1'b0, e);
        apb(1'b0, S1, 32'h0);
        chk("tx_empty", 1'b0, q[7]);
        tx_wait();
        repeat (3) @(posedge ref_clk_in);
        apb(1'b0, S1, 32'h0);
        chk("tx busy", 2'b10, q[7:6]);
        repeat (40) @(posedge ref_clk_in);
        rd(S1, 32'hc0);
        chk("tx byte", 8'ha5, u_eap_line_model.last_tx);
        pstrb_in <= 4'h0;
        apb(1'b1, DB, 32'h3c);
        pstrb_in <= 4'hf;
        chk("strobe", 1'b0, tx_pending_out);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 1'b1, e);
        apb(1'b1, CT, 32'h2fc);
        @(negedge ref_clk_in);
        chk("tx_irq", 1'b0, irq_out.tx_irq);
        apb(1'b1, CT, 32'h2fd);
        @(negedge ref_clk_in);
        chk("tx_irq", 1'b1, irq_out.tx_irq);
        apb(1'b1, CT, 32'h2fc);
        u_eap_line_model.rx(9'h05a, 4'h0);
        rd(S1, 32'he0);
        @(negedge ref_clk_in);
        chk("rx_irq", 1'b1, irq_out.rx_irq);
        rd(DB, 32'h5a);
        rd(S1, 32'hc0);
        rd(CT, 32'h2fc);
        u_eap_line_model.ev(4'b1000);
        rd(S1, 32'hd0);
        @(negedge ref_clk_in);
        chk("rx_irq", 1'b1, irq_out.rx_irq);
        rd(DB, 32'h5a);
        rd(S1, 32'hc0);
        u_eap_line_model.ev(4'b1000);
        rd(S1, 32'hc0);
        u_eap_line_model.rx(9'h011, 4'h0);
        rd(S1, 32'he0);
        u_eap_line_model.rx(9'h022, 4'h0);
        rd(DB, 32'h11);
        rd(S1, 32'hc8);
        @(negedge ref_clk_in);
        chk("err_irq", 1'b1, irq_out.err_irq);
        rd(DB, 32'h11);
        rd(S1, 32'hc0);
        u_eap_line_model.rx(9'h033, 4'b1110);
        rd(S1, 32'he7);
        @(negedge ref_clk_in);
        chk("err_irq", 1'b1, irq_out.err_irq);
        rd(DB, 32'h33);
        rd(S1, 32'hc0);
        apb(1'b1, CT, 32'h3fc);
        u_eap_line_model.rx(9'h100, 4'b0001);
        rd(S1, 32'he2);
        rd(S2, 32'h2);
        rd(CT, 32'h3fc);
        rd(DB, 32'h00);
        rd(S2, 32'h0);
        clr();
        u_eap_line_model.rx(9'h000, 4'b0001);
        rd(S2, 32'h0);
        clr();
        u_eap_line_model.ev(4'b0100);
        u_eap_line_model.rx(9'h000, 4'b0001);
        rd(S2, 32'h2);
        clr();
        apb(1'b1, CT, 32'h2fc);
        u_eap_line_model.rx(9'h080, 4'h0);
        rd(CT, 32'h6fc);
        clr();
        u_eap_line_model.ev(4'b0010);
        rd(S2, 32'h1);
        @(negedge ref_clk_in);
        chk("rx_irq", 1'b0, irq_out.rx_irq);
        u_eap_line_model.ev(4'b0001);
        rd(S2, 32'h0);
        u_eap_line_model.ev(4'b0010);
        u_eap_line_model.ev(4'b1000);
        rd(S2, 32'h0);
        // second reset must keep the received byte
        reset_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        rd(DB, 32'h80);
        rd(S1, 32'hc0);
        end_of_test();
    end
endmodule
